// ---- hw/ipx_ctrl.v ----
`timescale 1ns/1ns
`include "ipx_defines.vh"
module ipx_ctrl (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire        avs_response_err,
  input  wire        ext0_pin,
  input  wire        ext1_pin,
  input  wire [13:0] periph_req,
  input  wire        svc_done,
  output reg         core_irq_req_q,
  output reg  [3:0]  core_irq_src_q,
  output reg  [1:0]  core_irq_lvl_q,
  output wire        irq
);
  // Source index: 0 ext0,1 t0,2 ext1,3 t1,4 serial,5 brownout,6 adc,7 capture,
  // 8 i2c,9 keypad,12 watchdog,13 brake,14 spi,15 t2 (10,11 unused)
  reg  [7:0]  pri_l1_q, pri_h1_q, pri_l2_q, pri_h2_q;
  reg  [7:0]  ie_q, eie_q;
  reg         ext0_type_q, ext1_type_q, ext0_edge_q, ext1_edge_q;
  reg         ext0_pin_q, ext1_pin_q;
  reg  [2:0]  irq_stat_q, irq_en_q;
  reg  [3:0]  act_q;
  reg  [3:0]  act_src0_q, act_src1_q, act_src2_q;
  reg         rd_q;
  wire        ext0_flag, ext1_flag;
  wire [15:0] req_all;
  wire [15:0] en_all;
  wire [31:0] lvl_all;
  wire        arb_hit;
  wire [3:0]  arb_idx;
  wire [1:0]  arb_lvl;
  wire        wr_byte;
  wire        take;
  reg  [1:0]  cur_lvl;
  reg         any_act;
  integer     k;

  function [7:0] ipx_merge;
    input [7:0] old;
    input [7:0] nw;
    input [7:0] msk;
    ipx_merge = (old & ~msk) | (nw & msk);
  endfunction

  assign avs_waitrequest  = (avs_read | avs_write) & ~rd_q & avs_read;
  assign avs_response_err = 1'b0;
  assign wr_byte          = avs_write & avs_byteenable[0];

  assign ext0_flag = ext0_type_q ? ext0_edge_q : ~ext0_pin;
  assign ext1_flag = ext1_type_q ? ext1_edge_q : ~ext1_pin;

  assign req_all = {periph_req[13:10], 2'b00, periph_req[9:4], periph_req[1],
                    ext1_flag, periph_req[0], ext0_flag};
  assign en_all  = {eie_q[7:4], 2'b00, eie_q[1:0], eie_q[2], ie_q[6:0]} &
                   {16{ie_q[7]}};

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_lvl
      assign lvl_all[2*g +: 2]      = {pri_h1_q[g], pri_l1_q[g]};
      assign lvl_all[2*(g+8) +: 2]  = {pri_h2_q[g], pri_l2_q[g]};
    end
  endgenerate

  ipx_arbiter #(
    .NSRC (16)
  ) u_arb (
    .req  (req_all & en_all),
    .lvl  (lvl_all),
    .hit  (arb_hit),
    .idx  (arb_idx),
    .best (arb_lvl)
  );

  always @* begin
    any_act = |act_q;
    cur_lvl = 2'h0;
    for (k = 0; k < 4; k = k + 1) begin
      if (act_q[k]) begin
        cur_lvl = k[1:0];
      end
    end
  end

  // Take a request only when idle or above every level in service
  assign take = arb_hit & ~core_irq_req_q & (~any_act | (arb_lvl > cur_lvl));
  assign irq  = |(irq_stat_q & irq_en_q);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= avs_read & ~rd_q;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pri_l1_q       <= `IPX_RST_PRI;
      pri_h1_q       <= `IPX_RST_PRI;
      pri_l2_q       <= `IPX_RST_PRI;
      pri_h2_q       <= `IPX_RST_PRI;
      ie_q           <= `IPX_RST_CTRL;
      eie_q          <= `IPX_RST_CTRL;
      ext0_type_q    <= 1'b0;
      ext1_type_q    <= 1'b0;
      ext0_edge_q    <= 1'b0;
      ext1_edge_q    <= 1'b0;
      ext0_pin_q     <= 1'b1;
      ext1_pin_q     <= 1'b1;
      irq_stat_q     <= 3'h0;
      irq_en_q       <= 3'h0;
      act_q          <= 4'h0;
      act_src0_q     <= 4'h0;
      act_src1_q     <= 4'h0;
      act_src2_q     <= 4'h0;
      core_irq_req_q <= 1'b0;
      core_irq_src_q <= 4'h0;
      core_irq_lvl_q <= 2'h0;
      avs_readdata   <= 32'h0;
    end else begin
      ext0_pin_q <= ext0_pin;
      ext1_pin_q <= ext1_pin;
      // Software writes
      if (wr_byte) begin
        if (avs_address == `IPX_OFS_PRI_L1) begin
          pri_l1_q <= avs_writedata[7:0];
        end else if (avs_address == `IPX_OFS_PRI_H1) begin
          pri_h1_q <= avs_writedata[7:0];
        end else if (avs_address == `IPX_OFS_PRI_L2) begin
          pri_l2_q <= ipx_merge(8'h00, avs_writedata[7:0], `IPX_GRP2_MASK);
        end else if (avs_address == `IPX_OFS_PRI_H2) begin
          pri_h2_q <= ipx_merge(8'h00, avs_writedata[7:0], `IPX_GRP2_MASK);
        end else if (avs_address == `IPX_OFS_IE_GATE) begin
          ie_q <= avs_writedata[7:0];
        end else if (avs_address == `IPX_OFS_EIE_GATE) begin
          eie_q <= avs_writedata[7:0];
        end else if (avs_address == `IPX_OFS_TIMER_AND_EXTERNAL_INT_CONTROL_CTRL) begin
          ext0_type_q <= avs_writedata[`IPX_BIT_EXT0_TYPE];
          ext1_type_q <= avs_writedata[`IPX_BIT_EXT1_TYPE];
        end else if (avs_address == `IPX_OFS_IRQ_EN) begin
          irq_en_q <= avs_writedata[2:0];
        end
      end
      // Edge flags: set wins over software clear and service clear
      if (ext0_pin_q & ~ext0_pin & ext0_type_q) begin
        ext0_edge_q <= 1'b1;
      end else if ((wr_byte && avs_address == `IPX_OFS_TIMER_AND_EXTERNAL_INT_CONTROL_CTRL &&
                    !avs_writedata[`IPX_BIT_EXT0_FLAG]) ||
                   (take && arb_idx == 4'h0) || !ext0_type_q) begin
        ext0_edge_q <= 1'b0;
      end
      if (ext1_pin_q & ~ext1_pin & ext1_type_q) begin
        ext1_edge_q <= 1'b1;
      end else if ((wr_byte && avs_address == `IPX_OFS_TIMER_AND_EXTERNAL_INT_CONTROL_CTRL &&
                    !avs_writedata[`IPX_BIT_EXT1_FLAG]) ||
                   (take && arb_idx == 4'h2) || !ext1_type_q) begin
        ext1_edge_q <= 1'b0;
      end
      // Vector request to core; one pulse per accepted source
      core_irq_req_q <= take;
      if (take) begin
        core_irq_src_q <= arb_idx;
        core_irq_lvl_q <= arb_lvl;
        act_q[arb_lvl] <= 1'b1;
        if (any_act) begin
          act_src2_q <= act_src1_q;
          act_src1_q <= act_src0_q;
        end
        act_src0_q <= arb_idx;
      end else if (svc_done && any_act) begin
        act_q[cur_lvl] <= 1'b0;
        act_src0_q     <= act_src1_q;
        act_src1_q     <= act_src2_q;
      end
      // Sticky status: bit0 request taken, bit1 preemption, bit2 service end
      irq_stat_q <= (irq_stat_q & ~((wr_byte && avs_address == `IPX_OFS_IRQ_CLR) ?
                     avs_writedata[2:0] : 3'h0)) |
                    {svc_done & any_act, take & any_act, take};
      // Read path
      if (avs_read) begin
        avs_readdata <= 32'h0;
        if (avs_address == `IPX_OFS_PRI_L1) begin
          avs_readdata[7:0] <= pri_l1_q;
        end else if (avs_address == `IPX_OFS_PRI_H1) begin
          avs_readdata[7:0] <= pri_h1_q;
        end else if (avs_address == `IPX_OFS_PRI_L2) begin
          avs_readdata[7:0] <= pri_l2_q;
        end else if (avs_address == `IPX_OFS_PRI_H2) begin
          avs_readdata[7:0] <= pri_h2_q;
        end else if (avs_address == `IPX_OFS_IE_GATE) begin
          avs_readdata[7:0] <= ie_q;
        end else if (avs_address == `IPX_OFS_EIE_GATE) begin
          avs_readdata[7:0] <= eie_q;
        end else if (avs_address == `IPX_OFS_TIMER_AND_EXTERNAL_INT_CONTROL_CTRL) begin
          avs_readdata[7:0] <= {4'h0, ext1_flag, ext1_type_q, ext0_flag, ext0_type_q};
        end else if (avs_address == `IPX_OFS_IRQ_STAT) begin
          avs_readdata[2:0] <= irq_stat_q;
        end else if (avs_address == `IPX_OFS_IRQ_EN) begin
          avs_readdata[2:0] <= irq_en_q;
        end else if (avs_address == `IPX_OFS_SVC_CTRL) begin
          avs_readdata[7:0] <= {act_q, act_src0_q};
        end
      end
    end
  end
endmodule

// ---- hw/ipx_defines.vh ----
`ifndef IPX_DEFINES_VH
`define IPX_DEFINES_VH
// Register offsets (SFR addresses, byte index on the bus)
`define IPX_OFS_TIMER_AND_EXTERNAL_INT_CONTROL_CTRL   8'h88
`define IPX_OFS_IE_GATE     8'hA8
`define IPX_OFS_EIE_GATE    8'hE8
`define IPX_OFS_PRI_H1      8'hB7
`define IPX_OFS_PRI_L1      8'hB8
`define IPX_OFS_PRI_H2      8'hF7
`define IPX_OFS_PRI_L2      8'hFF
`define IPX_OFS_IRQ_STAT    8'hC0
`define IPX_OFS_IRQ_EN      8'hC1
`define IPX_OFS_IRQ_CLR     8'hC2
`define IPX_OFS_SVC_CTRL    8'hC3
// Field positions in the control register, and the gate bit (bit 7) of the IE gate register
`define IPX_BIT_EXT0_TYPE   0
`define IPX_BIT_EXT0_FLAG   1
`define IPX_BIT_EXT1_TYPE   2
`define IPX_BIT_EXT1_FLAG   3
`define IPX_BIT_GATE        7
// Writable-bit mask of group-2 priority registers; bits 3:2 are reserved
`define IPX_GRP2_MASK       8'hF3
// Reset values
`define IPX_RST_PRI         8'h00
`define IPX_RST_CTRL        8'h00
`endif

// ---- hw/ipx_arbiter.v ----
`timescale 1ns/1ns
// Picks the enabled request of the highest level; lowest index wins ties
module ipx_arbiter #(
  parameter NSRC = 16
) (
  input  wire [NSRC-1:0]   req,
  input  wire [2*NSRC-1:0] lvl,
  output reg               hit,
  output reg  [3:0]        idx,
  output reg  [1:0]        best
);
  integer i;
  always @* begin
    hit  = 1'b0;
    idx  = 4'h0;
    best = 2'h0;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (req[i] && (!hit || lvl[2*i +: 2] >= best)) begin
        hit  = 1'b1;
        idx  = i[3:0];
        best = lvl[2*i +: 2];
      end
    end
  end
endmodule

// ---- bench/ipx_core_model.sv ----
`timescale 1ns/1ns
// Core side: ends a service a few cycles after the last vector request; a new request restarts the count
module ipx_core_model #(
  parameter [3:0] DLY = 4'h4
) (
  input  wire core_clk,
  input  wire resetn,
  input  wire core_irq_req_q,
  output reg  svc_done
);
  reg [3:0] cnt_q;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 4'h0;
      svc_done <= 1'b0;
    end else begin
      svc_done <= (cnt_q == 4'h1);
      if (core_irq_req_q) cnt_q <= DLY;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule

// ---- bench/ipx_checker.sv ----
`timescale 1ns/1ns
module ipx_checker (
  input wire        core_clk,
  input wire        resetn,
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        ext0_pin,
  input wire        ext1_pin,
  input wire        core_irq_req_q
);
  reg  [2:0] mode_q;
  reg  [2:0] calm_q;
  reg  [1:0] pin_q;
  wire       wr0 = avs_write && avs_byteenable[0];
  wire       rdok = avs_read && !avs_waitrequest;
  wire       lv = rdok && avs_address == 8'h88 && calm_q == 3'h7;
  // Tracks gate and type bits, and cycles since pins or writes last moved
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= 3'h0;
      calm_q <= 3'h0;
      pin_q <= 2'h3;
    end else begin
      pin_q <= {ext1_pin, ext0_pin};
      if (wr0 && avs_address == 8'hA8) mode_q[2] <= avs_writedata[7];
      if (wr0 && avs_address == 8'h88) mode_q[1:0] <= {avs_writedata[2], avs_writedata[0]};
      if (wr0 || pin_q != {ext1_pin, ext0_pin}) calm_q <= 3'h0;
      else if (calm_q != 3'h7) calm_q <= calm_q + 3'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_rd_wait; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  property p_no_wait; !avs_read |-> !avs_waitrequest; endproperty
  property p_rd_up; rdok |-> avs_readdata[31:8] == 24'h0; endproperty
  property p_resv; rdok && avs_address inside {8'hF7, 8'hFF} |-> avs_readdata[3:2] == 2'h0;
  endproperty
  property p_pulse; core_irq_req_q |=> !core_irq_req_q; endproperty
  property p_gate; !mode_q[2] && !$past(mode_q[2]) |-> !core_irq_req_q; endproperty
  property p_lvl0; lv && !mode_q[0] |-> avs_readdata[1] == !ext0_pin; endproperty
  property p_lvl1; lv && !mode_q[1] |-> avs_readdata[3] == !ext1_pin; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait not one cycle");
  a_no_wait: assert property (p_no_wait) else $error("wait without read");
  a_rd_up: assert property (p_rd_up) else $error("read upper bits set");
  a_resv: assert property (p_resv) else $error("reserved bits set");
  a_pulse: assert property (p_pulse) else $error("vector pulse too long");
  a_gate: assert property (p_gate) else $error("vector with gate off");
  a_lvl0: assert property (p_lvl0) else $error("ext0 level flag");
  a_lvl1: assert property (p_lvl1) else $error("ext1 level flag");
  c_vec: cover property (core_irq_req_q);
  c_rd: cover property (rdok);
  c_lv: cover property (lv);
endmodule
bind ipx_ctrl ipx_checker u_chk (.core_clk(core_clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .ext0_pin(ext0_pin), .ext1_pin(ext1_pin), .core_irq_req_q(core_irq_req_q));

// ---- bench/tb_interrupt_priority_ext_detect.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_interrupt_priority_ext_detect;
  reg        core_clk = 1'b0;
  reg        resetn = 1'b0;
  reg [7:0]  avs_address = 8'h00;
  reg        avs_read = 1'b0;
  reg        avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg        ext0_pin = 1'b1;
  reg        ext1_pin = 1'b1;
  wire [31:0] avs_readdata;
  wire       avs_waitrequest;
  wire       svc_done;
  wire       core_irq_req_q;
  wire [3:0] core_irq_src_q;
  wire [1:0] core_irq_lvl_q;
  wire       irq;
  reg [31:0] q;
  reg [6:0]  seen;
  int        fail_count = 0;
  int        n_checks = 0;
  int        cyc = 0;
  always #5 core_clk = ~core_clk;
  ipx_ctrl dut (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(), .ext0_pin(ext0_pin), .ext1_pin(ext1_pin), .periph_req(14'h0),
    .svc_done(svc_done), .core_irq_req_q(core_irq_req_q), .core_irq_src_q(core_irq_src_q),
    .core_irq_lvl_q(core_irq_lvl_q), .irq(irq));
  ipx_core_model u_core (.core_clk(core_clk), .resetn(resetn),
    .core_irq_req_q(core_irq_req_q), .svc_done(svc_done));
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      print_verdict;
    end
  end
  // One Avalon transfer; held until waitrequest is sampled low at a rising edge
  task xfer(input bit w, input [7:0] a, input [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge core_clk); while (avs_waitrequest);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task pins(input [1:0] p);
    @(posedge core_clk);
    {ext1_pin, ext0_pin} <= p;
    repeat (10) @(posedge core_clk);
  endtask
  // Watches the vector port for a number of cycles
  task watch(input int n);
    seen = 7'h0;
    repeat (n) begin
      @(negedge core_clk);
      if (core_irq_req_q === 1'b1) seen = {1'b1, core_irq_lvl_q, core_irq_src_q};
    end
  endtask
  task t_regs;
    reg [7:0] ad [4];
    reg [7:0] ex [4];
    ad = '{8'hB7, 8'hB8, 8'hF7, 8'hFF};
    ex = '{8'hFF, 8'hFF, 8'hF3, 8'hF3};
    xfer(0, 8'hB7, 0); `CHK("pri_high_group1 reset", 32'h0, q)
    xfer(0, 8'hF7, 0); `CHK("pri_high_group2 reset", 32'h0, q)
    foreach (ad[i]) begin
      xfer(1, ad[i], 32'hFF);
      xfer(0, ad[i], 0); `CHK("priority readback", {24'h0, ex[i]}, q)
    end
    xfer(0, 8'h10, 0); `CHK("unmapped read", 32'h0, q)
  endtask
  task t_level;
    xfer(1, 8'h88, 0);
    for (int i = 0; i < 4; i++) begin
      pins(i[1:0]);
      xfer(0, 8'h88, 0); `CHK("level flags", ~i[1:0], {q[3], q[1]})
    end
  endtask
  task t_edge;
    xfer(1, 8'h88, 32'h05);
    pins(2'h0);
    pins(2'h3);
    xfer(0, 8'h88, 0); `CHK("edge flags latched", 4'hF, q[3:0])
    xfer(1, 8'h88, 32'h05);
    xfer(0, 8'h88, 0); `CHK("edge flags cleared", 4'h5, q[3:0])
  endtask
  task t_vec;
    xfer(1, 8'hC1, 32'h7);
    xfer(1, 8'hA8, 32'h81);
    @(posedge core_clk);
    ext0_pin <= 1'b0;
    watch(20); `CHK("vector lvl src", 7'h70, seen)
    xfer(0, 8'h88, 0); `CHK("flag cleared by service", 1'b0, q[1])
    `CHK("irq level", 1'b1, irq)
    xfer(0, 8'hC0, 0); `CHK("status", 32'h5, q)
    xfer(1, 8'hC2, 32'h7);
    xfer(0, 8'hC0, 0); `CHK("status cleared", 32'h0, q)
    `CHK("irq low", 1'b0, irq)
    pins(2'h3);
  endtask
  task t_gate;
    xfer(1, 8'hA8, 32'h01);
    @(posedge core_clk);
    ext0_pin <= 1'b0;
    watch(15); `CHK("no vector with gate off", 7'h0, seen)
    xfer(0, 8'h88, 0); `CHK("flag held", 1'b1, q[1])
    pins(2'h3);
    xfer(1, 8'h88, 32'h05);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs;
    t_level;
    t_edge;
    t_vec;
    t_gate;
    print_verdict;
  end
endmodule
